// >>> hw/rfps_pkg.sv
package rfps_pkg;
  // clock and timing
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned MIN_OFF_NS = 120;
  localparam int unsigned MIN_OFF_CYC = (MIN_OFF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned OV_DELAY_NS = 5000;
  localparam int unsigned OV_DELAY_CYC = (OV_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned HICCUP_BLANK_US = 1000;
  localparam int unsigned HICCUP_BLANK_CYC = (HICCUP_BLANK_US * 1000) / (CLK_PERIOD_PS / 1000);
  // register offsets
  localparam logic [7:0] ADDR_VIN_READING = 8'h0c;
  localparam logic [7:0] ADDR_VOUT_READING = 8'h0d;
  localparam logic [7:0] ADDR_IOUT_READING = 8'h0e;
  localparam logic [7:0] ADDR_TEMP_READING = 8'h0f;
  localparam logic [7:0] ADDR_GOOD_MODE = 8'h14;
  localparam logic [7:0] ADDR_OV_LIMIT = 8'h17;
  localparam logic [7:0] ADDR_GOOD_LEVEL = 8'h18;
  localparam logic [7:0] ADDR_THERMAL_LIMIT = 8'h19;
  // field positions and reset values
  localparam int unsigned GOOD_MODE_BIT_POS = 0;
  localparam int unsigned CODE_LSB = 0;
  localparam logic GOOD_MODE_RESET = 1'b1;
  localparam logic [1:0] OV_CODE_RESET = 2'h3;
  localparam logic [1:0] GOOD_CODE_RESET = 2'h2;
  localparam logic [1:0] THERMAL_CODE_RESET = 2'h3;
  // limits, in sense units (percent of target, 1/32 A, degrees C)
  localparam logic [7:0] OC_LIMIT_CODE = 8'hc0;
  localparam logic [7:0] CURRENT_ZERO = 8'h00;
  localparam logic [7:0] HYST_PCT = 8'h05;
  localparam logic signed [8:0] THERMAL_HYST_C = 9'sh019;
  localparam logic [7:0] SS_NEAR_PCT = 8'h62;

  // register port request, from logic on the same clock
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } rfps_reg_req_t;

  // analog sense and pin levels, all sampled from outside the clock domain
  typedef struct packed {
    logic enable;
    logic bias_ok;
    logic hs_request;
    logic [7:0] vin_code;
    logic [7:0] vout_code;
    logic [7:0] current_code;
    logic [8:0] temp_c;
    logic [7:0] feedback_pct;
    logic [7:0] ss_ref_pct;
  } rfps_sense_t;

  // over-voltage limit in percent of target
  function automatic logic [7:0] ov_limit_pct(input logic [1:0] code);
    case (code)
      2'h0: ov_limit_pct = 8'h69;
      2'h1: ov_limit_pct = 8'h6e;
      2'h2: ov_limit_pct = 8'h73;
      default: ov_limit_pct = 8'h78;
    endcase
  endfunction

  // output-good upper level in percent of target
  function automatic logic [7:0] good_level_pct(input logic [1:0] code);
    case (code)
      2'h0: good_level_pct = 8'h50;
      2'h1: good_level_pct = 8'h55;
      2'h2: good_level_pct = 8'h5a;
      default: good_level_pct = 8'h5f;
    endcase
  endfunction

  // thermal limit in degrees C
  function automatic logic signed [8:0] thermal_limit_c(input logic [1:0] code);
    case (code)
      2'h0: thermal_limit_c = 9'sh04b;
      2'h1: thermal_limit_c = 9'sh055;
      2'h2: thermal_limit_c = 9'sh07d;
      default: thermal_limit_c = 9'sh091;
    endcase
  endfunction
endpackage

// >>> hw/rfps_sync.sv
module rfps_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // levels from outside the domain
  input wire logic [WIDTH-1:0] async_in,
  // levels after two flip-flops
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_q; // first stage, read only by the second
  logic [WIDTH-1:0] stage2_q; // second stage

  // two-flop synchroniser
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= async_in;
      stage2_q <= stage1_q;
    end
  end

  assign sync_out = stage2_q;
endmodule

// >>> hw/rfps_timer.sv
module rfps_timer #(
  parameter int unsigned LIMIT = 15
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // count while high, clear while low
  input wire logic run_in,
  // high once LIMIT cycles of run have passed
  output logic done_out
);
  localparam int unsigned W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LIMIT_V = W'(LIMIT);

  logic [W-1:0] count_q; // saturating cycle count

  // count up to the limit and hold there
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      count_q <= '0;
    end else if (!run_in) begin
      count_q <= '0;
    end else if (count_q != LIMIT_V) begin
      count_q <= count_q + 1'b1;
    end
  end

  assign done_out = (count_q == LIMIT_V);
endmodule

// >>> hw/rfps_supervisor.sv
module rfps_supervisor
  import rfps_pkg::*;
#(
  parameter int unsigned HICCUP_CYC = rfps_pkg::HICCUP_BLANK_CYC
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // pins and analog sense, asynchronous
  input wire logic enable_in,
  input wire logic bias_ok_in,
  input wire logic hs_request_in,
  input wire logic [7:0] vin_code_in,
  input wire logic [7:0] vout_code_in,
  input wire logic [7:0] current_code_in,
  input wire logic [8:0] temp_c_in,
  input wire logic [7:0] feedback_sense_in,
  input wire logic [7:0] ss_ref_pct_in,
  // register port
  input wire rfps_pkg::rfps_reg_req_t reg_req_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // gate and status outputs
  output logic hs_gate_out,
  output logic ls_gate_out,
  output logic softstart_reset_out,
  output logic output_good_out
);
  import rfps_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  ////////////////////////////////////////////////////////////////////////////

  typedef enum logic [2:0] {
    ST_OFF,
    ST_RUN,
    ST_OC_DRAIN,
    ST_HICCUP,
    ST_OV_LATCH,
    ST_OT
  } rfps_state_t;

  rfps_sense_t sense_raw; // packed pin levels
  rfps_sense_t sense; // synchronised pin levels
  rfps_state_t state_q; // supervisor state
  rfps_state_t state_d;
  logic good_mode_q; // 1 threshold, 0 reference
  logic [1:0] ov_code_q; // over-voltage limit code
  logic [1:0] good_code_q; // output-good level code
  logic [1:0] thermal_code_q; // thermal limit code
  logic hs_q; // high-side gate
  logic hs_d;
  logic ls_q; // low-side gate
  logic ls_d;
  logic ss_reset_q; // soft-start held low
  logic good_q; // output good
  logic good_d;
  logic gate_seen_q; // first high-side pulse issued
  logic started_q; // output good reached once this start
  logic ov_discharge_q; // low side still discharging in latch
  logic [7:0] rdata_q; // read data
  logic rvalid_q; // read answer strobe

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisation
  ////////////////////////////////////////////////////////////////////////////

  assign sense_raw = '{enable: enable_in, bias_ok: bias_ok_in, hs_request: hs_request_in,
                       vin_code: vin_code_in, vout_code: vout_code_in,
                       current_code: current_code_in, temp_c: temp_c_in,
                       feedback_pct: feedback_sense_in, ss_ref_pct: ss_ref_pct_in};

  // all pins pass two flip-flops before use
  rfps_sync #(
    .WIDTH($bits(rfps_sense_t))
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .async_in(sense_raw),
    .sync_out(sense)
  );

  ////////////////////////////////////////////////////////////////////////////
  // thresholds and comparisons
  ////////////////////////////////////////////////////////////////////////////

  wire power_on = sense.enable && sense.bias_ok; // enable and bias both up
  wire [7:0] ov_limit = ov_limit_pct(ov_code_q);
  wire [7:0] ov_release = ov_limit - HYST_PCT; // latched discharge stop level
  wire [7:0] good_upper = good_level_pct(good_code_q);
  wire [7:0] good_lower = good_upper - HYST_PCT; // falling output-good level
  wire signed [8:0] ot_limit = thermal_limit_c(thermal_code_q);
  wire signed [8:0] ot_restart = ot_limit - THERMAL_HYST_C; // auto-restart level
  wire signed [8:0] temp_s = $signed(sense.temp_c); // die temperature

  wire ov_above = sense.feedback_pct > ov_limit; // feedback over limit
  wire ot_above = temp_s > ot_limit; // die too hot
  wire ot_cool = temp_s <= ot_restart;
  wire current_zero = sense.current_code == CURRENT_ZERO; // low-side current gone

  ////////////////////////////////////////////////////////////////////////////
  // timers
  ////////////////////////////////////////////////////////////////////////////

  logic ov_qualified; // over limit longer than the delay
  logic minoff_done; // low side has had its minimum time
  logic blank_done; // hiccup blanking has ended

  // runs in every active state, ramp included
  wire ov_run = ov_above && (state_q != ST_OFF) && (state_q != ST_OV_LATCH);
  rfps_timer #(
    .LIMIT(OV_DELAY_CYC)
  ) u_ov_timer (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .run_in(ov_run),
    .done_out(ov_qualified)
  );

  // minimum low-side interval after each high pulse
  wire minoff_run = (state_q == ST_RUN) && !hs_q;
  rfps_timer #(
    .LIMIT(MIN_OFF_CYC)
  ) u_minoff_timer (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .run_in(minoff_run),
    .done_out(minoff_done)
  );

  wire blank_run = state_q == ST_HICCUP;
  rfps_timer #(
    .LIMIT(HICCUP_CYC)
  ) u_blank_timer (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .run_in(blank_run),
    .done_out(blank_done)
  );

  // current sampled only in the minimum low-side window
  wire sample_window = minoff_run && !minoff_done;
  // over-current when current exceeds the fixed limit
  wire oc_fault = sample_window && (sense.current_code > OC_LIMIT_CODE);

  ////////////////////////////////////////////////////////////////////////////
  // supervisor state machine
  ////////////////////////////////////////////////////////////////////////////

  // next state; over-voltage first, then temperature, then current
  always_comb begin
    state_d = state_q;
    if (!power_on) begin
      // only enable or bias cycling leaves the latch
      state_d = ST_OFF;
    end else begin
      case (state_q)
        ST_OFF: begin
          state_d = ST_RUN;
        end
        ST_RUN: begin
          if (ov_qualified) begin
            state_d = ST_OV_LATCH;
          end else if (ot_above) begin
            state_d = ST_OT;
          end else if (oc_fault) begin
            state_d = ST_OC_DRAIN;
          end
        end
        ST_OC_DRAIN: begin
          if (ov_qualified) begin
            state_d = ST_OV_LATCH;
          end else if (ot_above) begin
            state_d = ST_OT;
          end else if (current_zero) begin
            state_d = ST_HICCUP;
          end
        end
        ST_HICCUP: begin
          if (ov_qualified) begin
            state_d = ST_OV_LATCH;
          end else if (ot_above) begin
            state_d = ST_OT;
          end else if (blank_done) begin
            state_d = ST_RUN;
          end
        end
        ST_OV_LATCH: begin
          // no restart of any kind from here
          state_d = ST_OV_LATCH;
        end
        ST_OT: begin
          if (ov_qualified) begin
            state_d = ST_OV_LATCH;
          end else if (ot_cool) begin
            state_d = ST_RUN;
          end
        end
        default: begin
          state_d = ST_OFF;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gate drive
  ////////////////////////////////////////////////////////////////////////////

  // high side only in run, on request, after the minimum low-side time;
  // once on it stays on while requested, as the timer clears under it
  // any fault state drops the high side at once
  assign hs_d = (state_d == ST_RUN) && (state_q == ST_RUN) && sense.hs_request && (hs_q || minoff_done);

  // low side per state
  always_comb begin
    case (state_d)
      ST_RUN: ls_d = !hs_d;
      // low side stays on until current reaches zero
      ST_OC_DRAIN: ls_d = 1'b1;
      // stop discharging below limit less hysteresis
      ST_OV_LATCH: ls_d = (state_q != ST_OV_LATCH) || (ov_discharge_q && (sense.feedback_pct >= ov_release));
      default: ls_d = 1'b0;
    endcase
  end

  // discharge flag, cleared for good once feedback falls low enough
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      ov_discharge_q <= 1'b0;
    end else if (state_d != ST_OV_LATCH) begin
      ov_discharge_q <= 1'b0;
    end else begin
      ov_discharge_q <= ls_d;
    end
  end

  // gate flip-flops; soft-start held low outside run
  // soft-start pulled low on over-current
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      hs_q <= 1'b0;
      ls_q <= 1'b0;
      ss_reset_q <= 1'b1;
    end else begin
      hs_q <= hs_d;
      ls_q <= ls_d;
      ss_reset_q <= (state_d != ST_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output good
  ////////////////////////////////////////////////////////////////////////////

  // first high pulse of this start has been issued
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      gate_seen_q <= 1'b0;
    end else if (state_q != ST_RUN) begin
      gate_seen_q <= 1'b0;
    end else if (hs_q) begin
      gate_seen_q <= 1'b1;
    end
  end

  // allowed only when powered, fault free and switching
  // not before the first high pulse
  wire good_allowed = (state_d == ST_RUN) && (state_q == ST_RUN) && gate_seen_q;

  // output good decision
  always_comb begin
    good_d = good_q;
    if (!good_allowed) begin
      // low on faults and when off
      good_d = 1'b0;
    end else if (!good_mode_q && !started_q) begin
      good_d = sense.ss_ref_pct >= SS_NEAR_PCT;
    end else if (sense.feedback_pct > good_upper) begin
      good_d = 1'b1;
    end else if (sense.feedback_pct < good_lower) begin
      good_d = 1'b0;
    end
  end

  // good flag and first-assertion tracking
  // mode bit picks start behaviour
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      good_q <= 1'b0;
      started_q <= 1'b0;
    end else begin
      good_q <= good_d;
      started_q <= good_allowed && (started_q || good_d);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port
  ////////////////////////////////////////////////////////////////////////////

  wire wr_mode = reg_req_in.write && (reg_req_in.addr == ADDR_GOOD_MODE); // mode write
  wire wr_ov = reg_req_in.write && (reg_req_in.addr == ADDR_OV_LIMIT); // limit write
  wire wr_good = reg_req_in.write && (reg_req_in.addr == ADDR_GOOD_LEVEL); // level write
  wire wr_ot = reg_req_in.write && (reg_req_in.addr == ADDR_THERMAL_LIMIT); // limit write

  // writable fields
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      good_mode_q <= GOOD_MODE_RESET;
      ov_code_q <= OV_CODE_RESET;
      good_code_q <= GOOD_CODE_RESET;
      thermal_code_q <= THERMAL_CODE_RESET;
    end else begin
      if (wr_mode) begin
        good_mode_q <= reg_req_in.wdata[GOOD_MODE_BIT_POS];
      end
      if (wr_ov) begin
        ov_code_q <= reg_req_in.wdata[CODE_LSB +: 2];
      end
      if (wr_good) begin
        good_code_q <= reg_req_in.wdata[CODE_LSB +: 2];
      end
      if (wr_ot) begin
        thermal_code_q <= reg_req_in.wdata[CODE_LSB +: 2];
      end
    end
  end

  // read selection; unused bits and unmapped offsets read zero
  // input voltage code passes straight through
  // output voltage code passes straight through
  logic [7:0] rsel;
  always_comb begin
    case (reg_req_in.addr)
      ADDR_VIN_READING: rsel = sense.vin_code;
      ADDR_VOUT_READING: rsel = sense.vout_code;
      ADDR_IOUT_READING: rsel = sense.current_code;
      ADDR_TEMP_READING: rsel = sense.temp_c[7:0];
      ADDR_GOOD_MODE: rsel = {7'h00, good_mode_q};
      ADDR_OV_LIMIT: rsel = {6'h00, ov_code_q};
      ADDR_GOOD_LEVEL: rsel = {6'h00, good_code_q};
      ADDR_THERMAL_LIMIT: rsel = {6'h00, thermal_code_q};
      default: rsel = 8'h00;
    endcase
  end

  // read answer one cycle after the request
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_req_in.read;
      if (reg_req_in.read) begin
        rdata_q <= rsel;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  ////////////////////////////////////////////////////////////////////////////

  assign hs_gate_out = hs_q;
  assign ls_gate_out = ls_q;
  assign softstart_reset_out = ss_reset_q;
  assign output_good_out = good_q;
  assign reg_rdata_out = rdata_q;
  assign reg_rvalid_out = rvalid_q;
endmodule

// >>> verif/rfps_supervisor_sva.sv
// watches the supervisor ports only
module rfps_supervisor_sva
  import rfps_pkg::*;
#(
  parameter int unsigned HICCUP_CYC = 20
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // pins and sense
  input wire logic enable_in,
  input wire logic bias_ok_in,
  input wire logic hs_request_in,
  input wire logic [7:0] vin_code_in,
  input wire logic [7:0] vout_code_in,
  input wire logic [7:0] current_code_in,
  input wire logic [8:0] temp_c_in,
  input wire logic [7:0] feedback_sense_in,
  input wire logic [7:0] ss_ref_pct_in,
  // register port
  input wire rfps_pkg::rfps_reg_req_t reg_req_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  // gates and status
  input wire logic hs_gate_out,
  input wire logic ls_gate_out,
  input wire logic softstart_reset_out,
  input wire logic output_good_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  ////////////////////////////////////////
  gate_excl_a: assert property (!(hs_gate_out && ls_gate_out))
    else $error("both gates on");
  min_off_a: assert property ($fell(hs_gate_out) |=> !hs_gate_out [*8])
    else $error("high side back too soon");
  fault_good_a: assert property (softstart_reset_out |-> !output_good_out)
    else $error("good during fault");
  enable_off_a: assert property (!enable_in [*5] |-> !output_good_out && !hs_gate_out)
    else $error("running while disabled");
  bias_off_a: assert property (!bias_ok_in [*5] |-> !hs_gate_out && !ls_gate_out)
    else $error("gates on without bias");
  read_ans_a: assert property (reg_req_in.read |=> reg_rvalid_out)
    else $error("read not answered");
  read_pulse_a: assert property (!reg_req_in.read |=> !reg_rvalid_out)
    else $error("stray read valid");
  data_hold_a: assert property (!reg_rvalid_out |-> $stable(reg_rdata_out))
    else $error("read data moved");
endmodule
bind rfps_supervisor rfps_supervisor_sva #(.HICCUP_CYC(HICCUP_CYC)) i_rfps_supervisor_sva (
  .clk_sys_in, .resetn_in, .enable_in, .bias_ok_in, .hs_request_in, .vin_code_in,
  .vout_code_in, .current_code_in, .temp_c_in, .feedback_sense_in, .ss_ref_pct_in,
  .reg_req_in, .reg_rdata_out, .reg_rvalid_out, .hs_gate_out, .ls_gate_out,
  .softstart_reset_out, .output_good_out
);

// >>> verif/rfps_host_model.sv
// host side of the register port
module rfps_host_model
  import rfps_pkg::*;
(
  // clock
  input wire logic clk_sys_in,
  // register port
  output rfps_pkg::rfps_reg_req_t req_out,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req_out = '0;
  // one write strobe, launched on a falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    req_out = '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(negedge clk_sys_in);
    req_out = '0;
  endtask
  // one read, data taken only with the valid pulse
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_in);
    req_out = '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
    @(negedge clk_sys_in);
    d = rvalid_in ? rdata_in : 8'hxx;
    req_out = '0;
  endtask
endmodule

// >>> verif/rfps_supervisor_test.sv
module rfps_supervisor_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rfps_pkg::*;
  localparam int HC = 20;
  logic clk_sys_in, resetn_in, enable_in, bias_ok_in;
  logic hs_request_in = 1'b0;
  logic [4:0] ph = 5'h00;
  logic [7:0] vin_code_in, vout_code_in, current_code_in, feedback_sense_in, ss_ref_pct_in, got;
  logic [8:0] temp_c_in;
  rfps_reg_req_t reg_req_in;
  logic [7:0] reg_rdata_out;
  logic reg_rvalid_out, hs_gate_out, ls_gate_out, softstart_reset_out, output_good_out;
  int n_errors = 0;
  int n_tests = 0;
  int n;
  // rows: addr, write flag, write data, expected read
  logic [31:0] rows [12] = '{32'h14000001, 32'h17000003, 32'h18000002, 32'h19000003,
    32'h0c0000c0, 32'h0d000087, 32'h0e000040, 32'h0f000032, 32'h1f000000,
    32'h0c01ffc0, 32'h1701fd01, 32'h19010000};
  rfps_supervisor #(.HICCUP_CYC(HC)) i_rfps_supervisor (
    .clk_sys_in, .resetn_in, .enable_in, .bias_ok_in, .hs_request_in, .vin_code_in,
    .vout_code_in, .current_code_in, .temp_c_in, .feedback_sense_in, .ss_ref_pct_in,
    .reg_req_in, .reg_rdata_out, .reg_rvalid_out, .hs_gate_out, .ls_gate_out,
    .softstart_reset_out, .output_good_out
  );
  rfps_host_model i_rfps_host_model (
    .clk_sys_in, .req_out(reg_req_in), .rdata_in(reg_rdata_out), .rvalid_in(reg_rvalid_out)
  );
  ////////////////////////////////////////
  // clock, 8 ns period
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  // modulator asks for the high side 24 of 32 cycles
  always @(negedge clk_sys_in) begin
    ph <= ph + 5'h01;
    hs_request_in <= ph[4:3] != 2'h0;
  end
  task automatic tally_and_finish();
    if (n_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // output conditions waited for
  function automatic logic cond(input int s);
    case (s)
      0: cond = output_good_out;
      1: cond = ls_gate_out && !hs_gate_out && softstart_reset_out && !output_good_out;
      2: cond = !softstart_reset_out;
      3: cond = !ls_gate_out && !hs_gate_out && softstart_reset_out;
      default: cond = !output_good_out;
    endcase
  endfunction
  // bounded wait, a timeout ends the run
  task automatic wait_c(input int s, input int lim, output int k);
    n_tests++;
    k = 0;
    while (cond(s) !== 1'b1) begin
      @(negedge clk_sys_in);
      k++;
      if (k > lim) begin
        n_errors++;
        tally_and_finish();
      end
    end
  endtask
  task automatic idle(input int c);
    repeat (c) @(negedge clk_sys_in);
  endtask
  ////////////////////////////////////////
  initial begin
    resetn_in = 1'b0;
    enable_in = 1'b0;
    bias_ok_in = 1'b1;
    vin_code_in = 8'hc0;
    vout_code_in = 8'h87;
    current_code_in = 8'h40;
    temp_c_in = 9'h032;
    feedback_sense_in = 8'h64;
    ss_ref_pct_in = 8'h64;
    idle(3);
    chk({4'h0, hs_gate_out, ls_gate_out, softstart_reset_out, output_good_out}, 8'h02);
    resetn_in = 1'b1;
    foreach (rows[i]) begin
      if (rows[i][16]) i_rfps_host_model.wr(rows[i][31:24], rows[i][15:8]);
      i_rfps_host_model.rd(rows[i][31:24], got);
      chk(got, rows[i][7:0]);
    end
    enable_in = 1'b1;
    wait_c(0, 200, n);
    // thermal limit now 75
    temp_c_in = 9'h04c;
    wait_c(3, 10, n);
    temp_c_in = 9'h033;
    idle(30);
    chk({7'h0, softstart_reset_out}, 8'h01);
    temp_c_in = 9'h032;
    wait_c(2, 10, n);
    wait_c(0, 200, n);
    // exactly 6 A does not trip
    current_code_in = 8'hc0;
    idle(64);
    chk({7'h0, softstart_reset_out}, 8'h00);
    current_code_in = 8'hc1;
    wait_c(1, 40, n);
    current_code_in = 8'h00;
    wait_c(3, 10, n);
    wait_c(2, 40, n);
    chk({7'h0, n >= HC}, 8'h01);
    wait_c(0, 200, n);
    // over-voltage limit now 110, fb 111
    feedback_sense_in = 8'h6f;
    idle(600);
    chk({7'h0, softstart_reset_out}, 8'h00);
    wait_c(1, 60, n);
    feedback_sense_in = 8'h6a;
    idle(20);
    chk({7'h0, ls_gate_out}, 8'h01);
    feedback_sense_in = 8'h68;
    wait_c(3, 10, n);
    feedback_sense_in = 8'h64;
    current_code_in = 8'hc1;
    idle(60);
    chk({6'h0, hs_gate_out, ls_gate_out}, 8'h00);
    current_code_in = 8'h00;
    bias_ok_in = 1'b0;
    idle(8);
    bias_ok_in = 1'b1;
    wait_c(0, 200, n);
    // reference mode start
    i_rfps_host_model.wr(8'h14, 8'h00);
    ss_ref_pct_in = 8'h5a;
    enable_in = 1'b0;
    idle(8);
    enable_in = 1'b1;
    idle(100);
    chk({7'h0, output_good_out}, 8'h00);
    ss_ref_pct_in = 8'h62;
    wait_c(0, 40, n);
    feedback_sense_in = 8'h56;
    idle(20);
    chk({7'h0, output_good_out}, 8'h01);
    feedback_sense_in = 8'h54;
    wait_c(4, 10, n);
    tally_and_finish();
  end
endmodule
